// ===== design/gcrb_pkg.sv
package gcrb_pkg;
  localparam logic [7:0] GLOBAL_ENABLE_ADDR = 8'h03;
  localparam logic [7:0] OUTPUT_PAIR_ENABLE_ADDR = 8'h04;
  localparam logic [7:0] GLOBAL_MODE_ENABLE_ADDR = 8'h05;
  localparam logic [7:0] ALARM_CLEAR_ADDR = 8'h06;
  localparam logic [7:0] RESERVED_MISC_ADDR = 8'h07;
  localparam logic [7:0] SCRATCHPAD_ADDR = 8'h08;
  localparam logic [7:0] LOCK_SYNC_CONTROL_ADDR = 8'h09;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int GE_RESEED_BIT = 5;
  localparam int GE_VCO_LSB = 3;
  localparam int GE_SYSREF_TIMER_BIT = 2;
  localparam int GE_OUTPUT_LOOP_BIT = 1;
  localparam int GE_REFERENCE_LOOP_BIT = 0;
  localparam int GM_SYNC_MODE_LSB = 6;
  localparam int GM_EXT_VCO_BIT = 5;
  localparam int GM_RF_SYNC_BIT = 4;
  localparam int GM_REF_PATH_LSB = 0;
  localparam int CLEAR_ALARMS_BIT = 0;
  localparam int LOCK_SYNC_DISABLE_BIT = 0;
  typedef enum logic [1:0] {
    GCRB_SYNC_OFF = 2'b00,
    GCRB_SYNC_CARRY = 2'b01,
    GCRB_SYNC_PULSE = 2'b10,
    GCRB_SYNC_AUTO = 2'b11
  } gcrb_sync_mode_t;
endpackage

// ===== design/gcrb_global_control.sv
`timescale 1ns/10ps
// Functional notes
// (R1) Global enable bit 5 turns on RF reseeding of the SYSREF path.
// (R2) Global enable bit 2 turns on the internal SYSREF time reference.
// (R3) Global enable bit 1 is the output loop master enable and bit 0 the reference loop master enable.
// (R4) Output pair enable bit k enables channels 2k and 2k+1 for channels 0 to 13.
// (R5) Sync pin mode 00 ignores the pin, 01 carries a pin rising edge through the output loop.
// (R6) Sync pin mode 10 turns a pin event into a pulse generator request like a general purpose input does.
// (R7) Sync pin mode 11 turns a pin event into a sync when an alarm exists, else a pulse request.
// (R8) Global mode bit 5 makes reference input 1 the external VCO input.
// (R9) Global mode bit 4 makes reference input 0 the external RF sync input.
// (R10) Reference path enable bit n enables reference input n for the reference loop.
// (R11) The scratchpad stores and returns written data and affects nothing.
// (R12) Lock sync disable 0 sends a sync up the output loop feedback divider on lock, 1 suppresses it.
// (R13) Writing 1 to clear alarms gives a one-cycle clear of all latched alarms.
module gcrb_global_control (
  input wire logic SYS_CLK, // System clock, 25 MHz
  input wire logic RST, // Synchronous reset, active high
  input wire logic WR_EN, // Register write strobe
  input wire logic [7:0] ADDR, // Register address
  input wire logic [7:0] WDATA, // Write data
  output logic [7:0] RDATA, // Read data, registered
  input wire logic SYNC_PIN, // External sync pin, asynchronous
  input wire logic ALARM_PRESENT, // Any alarm active
  input wire logic OUTPUT_LOOP_LOCKED, // Output loop lock, asynchronous
  output logic REFERENCE_LOOP_EN, // Reference loop master enable
  output logic OUTPUT_LOOP_EN, // Output loop master enable
  output logic SYSREF_TIMER_EN, // SYSREF time reference enable
  output logic RF_RESEED_EN, // RF reseed enable
  output logic [1:0] VCO_SELECT, // VCO selection
  output logic [13:0] CHANNEL_EN, // Per channel enable
  output logic EXT_VCO_MODE, // Reference input 1 as external VCO
  output logic RF_SYNC_MODE, // Reference input 0 as RF sync
  output logic [3:0] REFERENCE_PATH_EN, // Reference input path enables
  output logic SYNC_PULSE, // Sync through output loop, one cycle
  output logic PULSE_GEN_REQ, // Pulse generator request, one cycle
  output logic ALARM_CLEAR_PULSE, // Clear latched alarms, one cycle
  output logic LOCK_SYNC_PULSE // Sync up feedback divider on lock
);
  logic [7:0] ge_q, ge_d, pe_q, pe_d, gm_q, gm_d, ac_q, ac_d;
  logic [7:0] rm_q, rm_d, sp_q, sp_d, ls_q, ls_d, rd_q, rd_d;
  logic [2:0] pin_q, pin_d, lk_q, lk_d;
  logic sync_q, sync_d, pulse_q, pulse_d, clr_q, clr_d, lsync_q, lsync_d;
  logic pin_rise, lock_rise;
  gcrb_pkg::gcrb_sync_mode_t mode;

  assign mode = gcrb_pkg::gcrb_sync_mode_t'(gm_q[gcrb_pkg::GM_SYNC_MODE_LSB +: 2]);
  assign pin_rise = pin_q[1] & ~pin_q[2];
  assign lock_rise = lk_q[1] & ~lk_q[2];

  // Write decode and registered read mux
  always_comb begin
    ge_d = ge_q;
    pe_d = pe_q;
    gm_d = gm_q;
    ac_d = ac_q;
    rm_d = rm_q;
    sp_d = sp_q;
    ls_d = ls_q;
    clr_d = 1'b0;
    if (WR_EN) begin
      unique case (ADDR)
        gcrb_pkg::GLOBAL_ENABLE_ADDR: ge_d = WDATA;
        gcrb_pkg::OUTPUT_PAIR_ENABLE_ADDR: pe_d = WDATA;
        gcrb_pkg::GLOBAL_MODE_ENABLE_ADDR: gm_d = WDATA;
        gcrb_pkg::ALARM_CLEAR_ADDR: begin
          ac_d = {WDATA[7:1], 1'b0};
          clr_d = WDATA[gcrb_pkg::CLEAR_ALARMS_BIT]; // [R13]
        end
        gcrb_pkg::RESERVED_MISC_ADDR: rm_d = WDATA;
        gcrb_pkg::SCRATCHPAD_ADDR: sp_d = WDATA; // [R11]
        gcrb_pkg::LOCK_SYNC_CONTROL_ADDR: ls_d = WDATA;
        default: ;
      endcase
    end
    unique case (ADDR)
      gcrb_pkg::GLOBAL_ENABLE_ADDR: rd_d = ge_q;
      gcrb_pkg::OUTPUT_PAIR_ENABLE_ADDR: rd_d = pe_q;
      gcrb_pkg::GLOBAL_MODE_ENABLE_ADDR: rd_d = gm_q;
      gcrb_pkg::ALARM_CLEAR_ADDR: rd_d = ac_q;
      gcrb_pkg::RESERVED_MISC_ADDR: rd_d = rm_q;
      gcrb_pkg::SCRATCHPAD_ADDR: rd_d = sp_q; // [R11]
      gcrb_pkg::LOCK_SYNC_CONTROL_ADDR: rd_d = ls_q;
      default: rd_d = 8'h00;
    endcase
  end

  // Edge detect and sync mode dispatch
  always_comb begin
    pin_d = {pin_q[1:0], SYNC_PIN};
    lk_d = {lk_q[1:0], OUTPUT_LOOP_LOCKED};
    sync_d = 1'b0;
    pulse_d = 1'b0;
    if (pin_rise) begin
      unique case (mode)
        gcrb_pkg::GCRB_SYNC_OFF: ; // [R5]
        gcrb_pkg::GCRB_SYNC_CARRY: sync_d = 1'b1; // [R5]
        gcrb_pkg::GCRB_SYNC_PULSE: pulse_d = 1'b1; // [R6]
        gcrb_pkg::GCRB_SYNC_AUTO: begin
          sync_d = ALARM_PRESENT; // [R7]
          pulse_d = ~ALARM_PRESENT; // [R7]
        end
      endcase
    end
    lsync_d = lock_rise & ~ls_q[gcrb_pkg::LOCK_SYNC_DISABLE_BIT]; // [R12]
  end

  // Configuration registers, read data and clear strobe
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ge_q <= gcrb_pkg::REG_RESET;
      pe_q <= gcrb_pkg::REG_RESET;
      gm_q <= gcrb_pkg::REG_RESET;
      ac_q <= gcrb_pkg::REG_RESET;
      rm_q <= gcrb_pkg::REG_RESET;
      sp_q <= gcrb_pkg::REG_RESET;
      ls_q <= gcrb_pkg::REG_RESET;
      rd_q <= gcrb_pkg::REG_RESET;
      clr_q <= 1'b0;
    end else begin
      ge_q <= ge_d;
      pe_q <= pe_d;
      gm_q <= gm_d;
      ac_q <= ac_d;
      rm_q <= rm_d;
      sp_q <= sp_d;
      ls_q <= ls_d;
      rd_q <= rd_d;
      clr_q <= clr_d;
    end
  end

  // Synchronisers and event pulses
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pin_q <= 3'h0;
      lk_q <= 3'h0;
      sync_q <= 1'b0;
      pulse_q <= 1'b0;
      lsync_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
      lk_q <= lk_d;
      sync_q <= sync_d;
      pulse_q <= pulse_d;
      lsync_q <= lsync_d;
    end
  end

  assign RDATA = rd_q;
  assign RF_RESEED_EN = ge_q[gcrb_pkg::GE_RESEED_BIT]; // [R1]
  assign SYSREF_TIMER_EN = ge_q[gcrb_pkg::GE_SYSREF_TIMER_BIT]; // [R2]
  assign OUTPUT_LOOP_EN = ge_q[gcrb_pkg::GE_OUTPUT_LOOP_BIT]; // [R3]
  assign REFERENCE_LOOP_EN = ge_q[gcrb_pkg::GE_REFERENCE_LOOP_BIT]; // [R3]
  assign VCO_SELECT = ge_q[gcrb_pkg::GE_VCO_LSB +: 2];
  assign EXT_VCO_MODE = gm_q[gcrb_pkg::GM_EXT_VCO_BIT]; // [R8]
  assign RF_SYNC_MODE = gm_q[gcrb_pkg::GM_RF_SYNC_BIT]; // [R9]
  assign REFERENCE_PATH_EN = gm_q[gcrb_pkg::GM_REF_PATH_LSB +: 4]; // [R10]
  assign SYNC_PULSE = sync_q;
  assign PULSE_GEN_REQ = pulse_q;
  assign ALARM_CLEAR_PULSE = clr_q;
  assign LOCK_SYNC_PULSE = lsync_q;

  genvar k;
  generate
    for (k = 0; k < 7; k++) begin : g_pair
      assign CHANNEL_EN[2*k +: 2] = {2{pe_q[k]}}; // [R4]
      a_pair_follow: assert property (@(posedge SYS_CLK) disable iff (RST) // [R4]
        WR_EN && ADDR == gcrb_pkg::OUTPUT_PAIR_ENABLE_ADDR
        |=> CHANNEL_EN[2*k +: 2] == {2{$past(WDATA[k])}})
        else $error("Channel pair enable not written");
    end
  endgenerate

  a_reseed_follow: assert property (@(posedge SYS_CLK) disable iff (RST) // [R1]
    WR_EN && ADDR == gcrb_pkg::GLOBAL_ENABLE_ADDR |=> RF_RESEED_EN == $past(WDATA[5]))
    else $error("Reseed enable not written");
  a_timer_follow: assert property (@(posedge SYS_CLK) disable iff (RST) // [R2]
    WR_EN && ADDR == gcrb_pkg::GLOBAL_ENABLE_ADDR |=> SYSREF_TIMER_EN == $past(WDATA[2]))
    else $error("SYSREF timer enable not written");
  a_loop_enables: assert property (@(posedge SYS_CLK) disable iff (RST) // [R3]
    WR_EN && ADDR == gcrb_pkg::GLOBAL_ENABLE_ADDR |=> {OUTPUT_LOOP_EN, REFERENCE_LOOP_EN} == $past(WDATA[1:0]))
    else $error("Loop enables not written");
  a_pair_enable: assert property (@(posedge SYS_CLK) disable iff (RST) // [R4]
    WR_EN && ADDR == gcrb_pkg::OUTPUT_PAIR_ENABLE_ADDR |=> CHANNEL_EN[13:12] == {2{$past(WDATA[6])}}
    && CHANNEL_EN[1:0] == {2{$past(WDATA[0])}})
    else $error("Channel pair enable wrong");
  a_sync_off: assert property (@(posedge SYS_CLK) disable iff (RST) // [R5]
    mode == gcrb_pkg::GCRB_SYNC_OFF && $stable(mode) |=> !SYNC_PULSE && !PULSE_GEN_REQ)
    else $error("Pulse while sync pin disabled");
  a_sync_carry: assert property (@(posedge SYS_CLK) disable iff (RST) // [R5]
    pin_rise && mode == gcrb_pkg::GCRB_SYNC_CARRY |=> SYNC_PULSE && !PULSE_GEN_REQ)
    else $error("Pin edge not carried as sync");
  a_pulse_mode: assert property (@(posedge SYS_CLK) disable iff (RST) // [R6]
    pin_rise && mode == gcrb_pkg::GCRB_SYNC_PULSE |=> PULSE_GEN_REQ && !SYNC_PULSE)
    else $error("Pin edge not a pulse request");
  a_auto_mode: assert property (@(posedge SYS_CLK) disable iff (RST) // [R7]
    pin_rise && mode == gcrb_pkg::GCRB_SYNC_AUTO |=> SYNC_PULSE == $past(ALARM_PRESENT)
    && PULSE_GEN_REQ == !$past(ALARM_PRESENT))
    else $error("Auto mode choice wrong");
  a_input_modes: assert property (@(posedge SYS_CLK) disable iff (RST) // [R8]
    WR_EN && ADDR == gcrb_pkg::GLOBAL_MODE_ENABLE_ADDR |=> EXT_VCO_MODE == $past(WDATA[5])
    && RF_SYNC_MODE == $past(WDATA[4]) && REFERENCE_PATH_EN == $past(WDATA[3:0]))
    else $error("Input mode bits not written");
  a_scratch_read: assert property (@(posedge SYS_CLK) disable iff (RST) // [R11]
    WR_EN && ADDR == gcrb_pkg::SCRATCHPAD_ADDR ##1 ADDR == gcrb_pkg::SCRATCHPAD_ADDR && !WR_EN
    |=> RDATA == $past(WDATA, 2))
    else $error("Scratchpad readback wrong");
  a_lock_sync: assert property (@(posedge SYS_CLK) disable iff (RST) // [R12]
    lock_rise |=> LOCK_SYNC_PULSE == !$past(ls_q[0]))
    else $error("Lock sync gating wrong");
  a_clear_once: assert property (@(posedge SYS_CLK) disable iff (RST) // [R13]
    WR_EN && ADDR == gcrb_pkg::ALARM_CLEAR_ADDR && WDATA[0] |=> ALARM_CLEAR_PULSE ##1 (!ALARM_CLEAR_PULSE
    || $past(WR_EN && ADDR == gcrb_pkg::ALARM_CLEAR_ADDR && WDATA[0])))
    else $error("Alarm clear not one shot");

  // Register hold and readback checks
  a_enable_hold: assert property (@(posedge SYS_CLK) disable iff (RST) // [R3]
    !(WR_EN && ADDR == gcrb_pkg::GLOBAL_ENABLE_ADDR)
    |=> $stable({RF_RESEED_EN, VCO_SELECT, SYSREF_TIMER_EN, OUTPUT_LOOP_EN, REFERENCE_LOOP_EN}))
    else $error("Global enables changed without a write");
  a_enable_readback: assert property (@(posedge SYS_CLK) disable iff (RST) // [R3]
    WR_EN && ADDR == gcrb_pkg::GLOBAL_ENABLE_ADDR ##1 ADDR == gcrb_pkg::GLOBAL_ENABLE_ADDR && !WR_EN
    |=> RDATA == $past(WDATA, 2))
    else $error("Global enable readback wrong");
  a_pair_hold: assert property (@(posedge SYS_CLK) disable iff (RST) // [R4]
    !(WR_EN && ADDR == gcrb_pkg::OUTPUT_PAIR_ENABLE_ADDR)
    |=> $stable(CHANNEL_EN))
    else $error("Channel enables changed without a write");
  a_pair_readback: assert property (@(posedge SYS_CLK) disable iff (RST) // [R4]
    WR_EN && ADDR == gcrb_pkg::OUTPUT_PAIR_ENABLE_ADDR ##1 ADDR == gcrb_pkg::OUTPUT_PAIR_ENABLE_ADDR && !WR_EN
    |=> RDATA == $past(WDATA, 2))
    else $error("Pair enable readback wrong");
  a_rf_sync_follow: assert property (@(posedge SYS_CLK) disable iff (RST) // [R9]
    WR_EN && ADDR == gcrb_pkg::GLOBAL_MODE_ENABLE_ADDR
    |=> RF_SYNC_MODE == $past(WDATA[gcrb_pkg::GM_RF_SYNC_BIT]))
    else $error("RF sync input mode not written");
  a_ref_path_follow: assert property (@(posedge SYS_CLK) disable iff (RST) // [R10]
    WR_EN && ADDR == gcrb_pkg::GLOBAL_MODE_ENABLE_ADDR
    |=> REFERENCE_PATH_EN == $past(WDATA[gcrb_pkg::GM_REF_PATH_LSB +: 4]))
    else $error("Reference path enables not written");
  a_mode_hold: assert property (@(posedge SYS_CLK) disable iff (RST) // [R10]
    !(WR_EN && ADDR == gcrb_pkg::GLOBAL_MODE_ENABLE_ADDR)
    |=> $stable({EXT_VCO_MODE, RF_SYNC_MODE, REFERENCE_PATH_EN}))
    else $error("Input modes changed without a write");
  a_mode_readback: assert property (@(posedge SYS_CLK) disable iff (RST) // [R10]
    WR_EN && ADDR == gcrb_pkg::GLOBAL_MODE_ENABLE_ADDR ##1 ADDR == gcrb_pkg::GLOBAL_MODE_ENABLE_ADDR && !WR_EN
    |=> RDATA == $past(WDATA, 2))
    else $error("Global mode readback wrong");
  a_scratch_hold: assert property (@(posedge SYS_CLK) disable iff (RST) // [R11]
    !(WR_EN && ADDR == gcrb_pkg::SCRATCHPAD_ADDR)
    |=> $stable(sp_q))
    else $error("Scratchpad changed without a write");
  a_scratch_isolated: assert property (@(posedge SYS_CLK) disable iff (RST) // [R11]
    WR_EN && ADDR == gcrb_pkg::SCRATCHPAD_ADDR
    |=> $stable({CHANNEL_EN, REFERENCE_PATH_EN, OUTPUT_LOOP_EN, REFERENCE_LOOP_EN, EXT_VCO_MODE}))
    else $error("Scratchpad write changed device control");
  a_lock_readback: assert property (@(posedge SYS_CLK) disable iff (RST) // [R12]
    WR_EN && ADDR == gcrb_pkg::LOCK_SYNC_CONTROL_ADDR ##1 ADDR == gcrb_pkg::LOCK_SYNC_CONTROL_ADDR && !WR_EN
    |=> RDATA == $past(WDATA, 2))
    else $error("Lock sync control readback wrong");
  a_clear_reads_zero: assert property (@(posedge SYS_CLK) disable iff (RST) // [R13]
    ADDR == gcrb_pkg::ALARM_CLEAR_ADDR
    |=> !RDATA[gcrb_pkg::CLEAR_ALARMS_BIT])
    else $error("Clear alarms bit read back as one");
  a_clear_quiet: assert property (@(posedge SYS_CLK) disable iff (RST) // [R13]
    !(WR_EN && ADDR == gcrb_pkg::ALARM_CLEAR_ADDR && WDATA[gcrb_pkg::CLEAR_ALARMS_BIT])
    |=> !ALARM_CLEAR_PULSE)
    else $error("Alarm clear without a write");

  // Event pulse checks
  a_off_no_sync: assert property (@(posedge SYS_CLK) disable iff (RST) // [R5]
    pin_rise && mode == gcrb_pkg::GCRB_SYNC_OFF
    |=> !SYNC_PULSE && !PULSE_GEN_REQ)
    else $error("Pin edge acted while disabled");
  a_sync_no_edge: assert property (@(posedge SYS_CLK) disable iff (RST) // [R5]
    !pin_rise
    |=> !SYNC_PULSE && !PULSE_GEN_REQ)
    else $error("Pin pulse without a pin edge");
  a_sync_single: assert property (@(posedge SYS_CLK) disable iff (RST) // [R5]
    SYNC_PULSE
    |=> !SYNC_PULSE)
    else $error("Sync pulse longer than one cycle");
  a_pulse_single: assert property (@(posedge SYS_CLK) disable iff (RST) // [R6]
    PULSE_GEN_REQ
    |=> !PULSE_GEN_REQ)
    else $error("Pulse request longer than one cycle");
  a_sync_exclusive: assert property (@(posedge SYS_CLK) disable iff (RST) // [R7]
    SYNC_PULSE
    |-> !PULSE_GEN_REQ)
    else $error("Sync and pulse request together");
  a_lock_quiet: assert property (@(posedge SYS_CLK) disable iff (RST) // [R12]
    !lock_rise
    |=> !LOCK_SYNC_PULSE)
    else $error("Lock sync without a lock edge");
  a_lock_disabled: assert property (@(posedge SYS_CLK) disable iff (RST) // [R12]
    ls_q[gcrb_pkg::LOCK_SYNC_DISABLE_BIT]
    |=> !LOCK_SYNC_PULSE)
    else $error("Lock sync while disabled");
  a_lock_single: assert property (@(posedge SYS_CLK) disable iff (RST) // [R12]
    LOCK_SYNC_PULSE
    |=> !LOCK_SYNC_PULSE)
    else $error("Lock sync longer than one cycle");
endmodule

// ===== tb/gcrb_global_control_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
module gcrb_global_control_tb;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic WR_EN = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic SYNC_PIN = 1'b0;
  logic ALARM_PRESENT = 1'b0;
  logic OUTPUT_LOOP_LOCKED = 1'b0;
  logic [7:0] RDATA;
  logic REFERENCE_LOOP_EN, OUTPUT_LOOP_EN, SYSREF_TIMER_EN, RF_RESEED_EN, EXT_VCO_MODE, RF_SYNC_MODE;
  logic [1:0] VCO_SELECT;
  logic [13:0] CHANNEL_EN;
  logic [3:0] REFERENCE_PATH_EN;
  logic SYNC_PULSE, PULSE_GEN_REQ, ALARM_CLEAR_PULSE, LOCK_SYNC_PULSE;
  int bad_count = 0;
  int check_count = 0;
  gcrb_global_control gcrb_global_control_i (.SYS_CLK(SYS_CLK), .RST(RST), .WR_EN(WR_EN), .ADDR(ADDR),
    .WDATA(WDATA), .RDATA(RDATA), .SYNC_PIN(SYNC_PIN), .ALARM_PRESENT(ALARM_PRESENT),
    .OUTPUT_LOOP_LOCKED(OUTPUT_LOOP_LOCKED), .REFERENCE_LOOP_EN(REFERENCE_LOOP_EN),
    .OUTPUT_LOOP_EN(OUTPUT_LOOP_EN), .SYSREF_TIMER_EN(SYSREF_TIMER_EN), .RF_RESEED_EN(RF_RESEED_EN),
    .VCO_SELECT(VCO_SELECT), .CHANNEL_EN(CHANNEL_EN), .EXT_VCO_MODE(EXT_VCO_MODE), .RF_SYNC_MODE(RF_SYNC_MODE),
    .REFERENCE_PATH_EN(REFERENCE_PATH_EN), .SYNC_PULSE(SYNC_PULSE), .PULSE_GEN_REQ(PULSE_GEN_REQ),
    .ALARM_CLEAR_PULSE(ALARM_CLEAR_PULSE), .LOCK_SYNC_PULSE(LOCK_SYNC_PULSE));
  initial begin
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    WR_EN <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge SYS_CLK);
    WR_EN <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge SYS_CLK);
    ADDR <= a;
    @(posedge SYS_CLK);
    #1;
    `CHK(RDATA, e)
  endtask
  // Raise pin or lock, count each pulse output over the sync latency window
  task automatic evt(input logic lk, input logic [3:0] es, input logic [3:0] ep, input logic [3:0] el);
    logic [3:0] s, p, l;
    s = 4'h0;
    p = 4'h0;
    l = 4'h0;
    @(posedge SYS_CLK);
    if (lk) OUTPUT_LOOP_LOCKED <= 1'b1;
    else SYNC_PIN <= 1'b1;
    repeat (8) begin
      @(posedge SYS_CLK);
      #1;
      s = s + SYNC_PULSE;
      p = p + PULSE_GEN_REQ;
      l = l + LOCK_SYNC_PULSE;
    end
    @(posedge SYS_CLK);
    SYNC_PIN <= 1'b0;
    OUTPUT_LOOP_LOCKED <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    `CHK({s, p, l}, {es, ep, el})
  endtask
  initial begin
    repeat (3) @(posedge SYS_CLK);
    RST <= 1'b0;
    for (int a = 3; a < 10; a++) rd(8'(a), 8'h00);
    $display("test reset done");
    wr(8'h03, 8'h25);
    `CHK({RF_RESEED_EN, VCO_SELECT, SYSREF_TIMER_EN, OUTPUT_LOOP_EN, REFERENCE_LOOP_EN}, 6'b100101)
    wr(8'h03, 8'hda);
    `CHK({RF_RESEED_EN, VCO_SELECT, SYSREF_TIMER_EN, OUTPUT_LOOP_EN, REFERENCE_LOOP_EN}, 6'b011010)
    rd(8'h03, 8'hda);
    for (int k = 0; k < 7; k++) begin
      wr(8'h04, 8'h01 << k);
      `CHK(CHANNEL_EN, 14'h3 << (2 * k))
    end
    wr(8'h04, 8'h80);
    `CHK(CHANNEL_EN, 14'h0)
    wr(8'h05, 8'h25);
    `CHK({EXT_VCO_MODE, RF_SYNC_MODE, REFERENCE_PATH_EN}, 6'b100101)
    wr(8'h05, 8'h1a);
    `CHK({EXT_VCO_MODE, RF_SYNC_MODE, REFERENCE_PATH_EN}, 6'b011010)
    $display("test enables done");
    wr(8'h08, 8'h5a);
    `CHK({CHANNEL_EN, REFERENCE_PATH_EN}, 18'h0000a)
    wr(8'h0a, 8'hff);
    rd(8'h0a, 8'h00);
    rd(8'h08, 8'h5a);
    wr(8'h06, 8'h81);
    `CHK(ALARM_CLEAR_PULSE, 1'b1)
    @(posedge SYS_CLK);
    #1;
    `CHK(ALARM_CLEAR_PULSE, 1'b0)
    rd(8'h06, 8'h80);
    $display("test scratch and clear done");
    wr(8'h05, 8'h00);
    evt(1'b0, 4'd0, 4'd0, 4'd0);
    wr(8'h05, 8'h40);
    evt(1'b0, 4'd1, 4'd0, 4'd0);
    wr(8'h05, 8'h80);
    evt(1'b0, 4'd0, 4'd1, 4'd0);
    wr(8'h05, 8'hc0);
    evt(1'b0, 4'd0, 4'd1, 4'd0);
    @(posedge SYS_CLK);
    ALARM_PRESENT <= 1'b1;
    evt(1'b0, 4'd1, 4'd0, 4'd0);
    wr(8'h09, 8'h00);
    evt(1'b1, 4'd0, 4'd0, 4'd1);
    wr(8'h09, 8'h01);
    evt(1'b1, 4'd0, 4'd0, 4'd0);
    rd(8'h09, 8'h01);
    $display("test events done");
    tally_and_finish;
  end
  initial begin
    repeat (3000) @(posedge SYS_CLK);
    bad_count++;
    tally_and_finish;
  end
endmodule
